// ==== hdl/ebac_ctrl.sv ====
// Byte access controller for on-chip nonvolatile data storage.
// Assumes the CPU drives a special-register bus with sector select
// and that write-done flag clearing comes from software as a pulse.
`timescale 1ns/10ps

module ebac_ctrl #(
    parameter int LOC_BITS    = ebac_pkg::LOC_BITS_LARGE,
    parameter int WRITE_TICKS = ebac_pkg::WRITE_TICKS,
    parameter int READ_CYCLES = ebac_pkg::READ_CYCLES,
    parameter int TICK_DIV    = ebac_pkg::TICK_DIV
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_sector,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       done_flag_clr,
    output logic            nvm_done_flag,
    output logic            nvm_done_pulse,
    output logic            nvm_busy
);
    localparam logic [7:0] LOC_MASK = 8'((1 << LOC_BITS) - 1);
    localparam int         RD_MAX   = READ_CYCLES + 2;

    ebac_pkg::ebac_state_t state_r;
    ebac_pkg::ebac_state_t state_nxt;

    logic [7:0]          byte_location_reg;
    logic [7:0]          byte_value_reg;
    logic                program_permit;
    logic                wr_start_r;
    logic                fetch_permit;
    logic                rd_start_r;
    logic [15:0]         tick_div_r;
    logic                slow_tick;
    logic [31:0]         cnt_r;
    logic                wr_fin;
    logic                rd_fin;
    logic                wr_go;
    logic                rd_go;
    logic                cmd_wr;
    logic [7:0]          mem_q;
    logic [7:0]          nvm_command_reg;

    // Command is only visible through the indirect sector window
    function automatic logic cmd_hit(input logic [7:0] a, input logic [7:0] s);
        cmd_hit = (a == ebac_pkg::CMD_OFS) && (s == ebac_pkg::CMD_SECTOR);
    endfunction

    assign cmd_wr = sfr_wr && cmd_hit(sfr_addr, sfr_sector);

    assign nvm_command_reg = {4'h0, program_permit, wr_start_r, fetch_permit, rd_start_r};

    // Permit must already be set before this write; mixed requests rejected
    assign wr_go = cmd_wr && sfr_wdata[ebac_pkg::CMD_WR_START] && !sfr_wdata[ebac_pkg::CMD_RD_START]
                   && program_permit && (state_r == ebac_pkg::EBAC_IDLE);
    assign rd_go = cmd_wr && sfr_wdata[ebac_pkg::CMD_RD_START] && !sfr_wdata[ebac_pkg::CMD_WR_START]
                   && fetch_permit && (state_r == ebac_pkg::EBAC_IDLE);

    // Free-running write timer; its phase is unrelated to the start,
    // so write length varies by up to one tick
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tick_div_r <= 16'h0000;
        end else if (tick_div_r == 16'(TICK_DIV - 1)) begin
            tick_div_r <= 16'h0000;
        end else begin
            tick_div_r <= tick_div_r + 16'h0001;
        end
    end

    assign slow_tick = (tick_div_r == 16'(TICK_DIV - 1));

    assign wr_fin = (state_r == ebac_pkg::EBAC_WRITE) && slow_tick
                    && (cnt_r == 32'(WRITE_TICKS - 1));
    assign rd_fin = (state_r == ebac_pkg::EBAC_READ) && (cnt_r == 32'(READ_CYCLES - 1));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ebac_pkg::EBAC_IDLE: begin
                if (wr_go) begin
                    state_nxt = ebac_pkg::EBAC_WRITE;
                end else if (rd_go) begin
                    state_nxt = ebac_pkg::EBAC_READ;
                end
            end
            ebac_pkg::EBAC_READ: begin
                if (rd_fin) begin
                    state_nxt = ebac_pkg::EBAC_IDLE;
                end
            end
            ebac_pkg::EBAC_WRITE: begin
                if (wr_fin) begin
                    state_nxt = ebac_pkg::EBAC_IDLE;
                end
            end
            default: begin
                state_nxt = ebac_pkg::EBAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_r <= ebac_pkg::EBAC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Read counts system clocks, write counts slow ticks
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cnt_r <= 32'h0000_0000;
        end else if (wr_go || rd_go || rd_fin || wr_fin) begin
            cnt_r <= 32'h0000_0000;
        end else if (state_r == ebac_pkg::EBAC_READ) begin
            cnt_r <= cnt_r + 32'h0000_0001;
        end else if ((state_r == ebac_pkg::EBAC_WRITE) && slow_tick) begin
            cnt_r <= cnt_r + 32'h0000_0001;
        end
    end

    // Permit bits are plain software bits
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            program_permit <= ebac_pkg::CMD_RESET[ebac_pkg::CMD_PROG_PERMIT];
            fetch_permit   <= ebac_pkg::CMD_RESET[ebac_pkg::CMD_FETCH_PERMIT];
        end else if (cmd_wr) begin
            program_permit <= sfr_wdata[ebac_pkg::CMD_PROG_PERMIT];
            fetch_permit   <= sfr_wdata[ebac_pkg::CMD_FETCH_PERMIT];
        end
    end

    // Start bits: software can only set them, hardware clears them
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_start_r <= ebac_pkg::CMD_RESET[ebac_pkg::CMD_WR_START];
        end else if (wr_go) begin
            wr_start_r <= 1'b1;
        end else if (wr_fin) begin
            wr_start_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rd_start_r <= ebac_pkg::CMD_RESET[ebac_pkg::CMD_RD_START];
        end else if (rd_go) begin
            rd_start_r <= 1'b1;
        end else if (rd_fin) begin
            rd_start_r <= 1'b0;
        end
    end

    // Location register: no reset value, decoded in every sector
    always_ff @(posedge mclk) begin
        if (sfr_wr && (sfr_addr == ebac_pkg::LOC_OFS)) begin
            byte_location_reg <= sfr_wdata & LOC_MASK;
        end
    end

    // Value register; a finished read overrides a software write
    always_ff @(posedge mclk) begin
        if (rd_fin) begin
            byte_value_reg <= mem_q;
        end else if (sfr_wr && (sfr_addr == ebac_pkg::VAL_OFS)) begin
            byte_value_reg <= sfr_wdata;
        end
    end

    ebac_array #(
        .AW (LOC_BITS)
    ) u_array (
        .mclk  (mclk),
        .we    (wr_fin),
        .addr  (byte_location_reg[LOC_BITS-1:0]),
        .wdata (byte_value_reg),
        .q     (mem_q)
    );

    // Sticky done flag; a set in the clearing cycle wins
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            nvm_done_flag <= 1'b0;
        end else if (wr_fin) begin
            nvm_done_flag <= 1'b1;
        end else if (done_flag_clr) begin
            nvm_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            nvm_done_pulse <= 1'b0;
        end else begin
            nvm_done_pulse <= wr_fin;
        end
    end

    assign nvm_busy = (state_r != ebac_pkg::EBAC_IDLE);

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sfr_rdata <= ebac_pkg::RDATA_RESET;
        end else if (sfr_rd) begin
            if (cmd_hit(sfr_addr, sfr_sector)) begin
                sfr_rdata <= nvm_command_reg;
            end else if (sfr_addr == ebac_pkg::LOC_OFS) begin
                sfr_rdata <= byte_location_reg & LOC_MASK;
            end else if (sfr_addr == ebac_pkg::VAL_OFS) begin
                sfr_rdata <= byte_value_reg;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_cmd_upper_zero: assert property (
        (sfr_rd && cmd_hit(sfr_addr, sfr_sector)) |=> (sfr_rdata[7:4] == 4'h0))
        else $error("command upper bits not zero");

    a_loc_top_bit: assert property (
        (sfr_rd && (sfr_addr == ebac_pkg::LOC_OFS) && (LOC_BITS == 7)) |=> !sfr_rdata[7])
        else $error("location bit 7 not zero on small variant");

    a_write_needs_permit: assert property (
        (state_r == ebac_pkg::EBAC_IDLE) ##1 (state_r == ebac_pkg::EBAC_WRITE)
        |-> $past(program_permit))
        else $error("write began without prior permit");

    a_read_needs_permit: assert property (
        $rose(rd_start_r) |-> $past(fetch_permit))
        else $error("read began without prior permit");

    a_read_bit_busy: assert property (
        (state_r == ebac_pkg::EBAC_READ) |-> rd_start_r)
        else $error("read start low during read");

    a_read_ends_bounded: assert property (
        $rose(rd_start_r) |-> ##[1:RD_MAX] !rd_start_r)
        else $error("read did not finish in time");

    a_read_loads_value: assert property (
        rd_fin |=> (byte_value_reg == $past(mem_q)) && !rd_start_r)
        else $error("read byte not captured");

    a_done_sets_flag: assert property (
        wr_fin |=> (nvm_done_flag && nvm_done_pulse && !wr_start_r))
        else $error("write end not reported");

    a_write_holds_busy: assert property (
        ((state_r == ebac_pkg::EBAC_WRITE) && !wr_fin) |=> (state_r == ebac_pkg::EBAC_WRITE) && wr_start_r)
        else $error("write left early");

    a_wr_only_timer: assert property (
        wr_fin |-> slow_tick && $past(slow_tick, TICK_DIV))
        else $error("write ended off the timer tick");
endmodule // ebac_ctrl

// ==== common/ebac_pkg.sv ====
// Constants for the byte-wide nonvolatile access controller.
// Assumes a 40 MHz system clock and a CPU special-register bus with sector select.
package ebac_pkg;

    // Clock and timer figures
    localparam int CLK_NS         = 25;
    localparam int TICK_NS        = 1000;
    localparam int TICK_DIV       = TICK_NS / CLK_NS;
    localparam int WRITE_TIME_US  = 2000;
    localparam int WRITE_TICKS    = (WRITE_TIME_US * 1000) / TICK_NS;
    localparam int READ_TIME_NS   = 100;
    localparam int READ_CYCLES    = (READ_TIME_NS + CLK_NS - 1) / CLK_NS;

    // Variant: 7 address bits for 128 bytes, 8 for 256 bytes
    localparam int LOC_BITS_SMALL = 7;
    localparam int LOC_BITS_LARGE = 8;

    // Register offsets
    localparam logic [7:0] LOC_OFS    = 8'h1a;
    localparam logic [7:0] VAL_OFS    = 8'h1b;
    localparam logic [7:0] CMD_OFS    = 8'h40;
    localparam logic [7:0] CMD_SECTOR = 8'h01;

    // Command register fields
    localparam int CMD_PROG_PERMIT  = 3;
    localparam int CMD_WR_START     = 2;
    localparam int CMD_FETCH_PERMIT = 1;
    localparam int CMD_RD_START     = 0;
    localparam logic [3:0] CMD_RESET = 4'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    typedef enum logic [1:0] {
        EBAC_IDLE  = 2'b00,
        EBAC_READ  = 2'b01,
        EBAC_WRITE = 2'b10
    } ebac_state_t;

endpackage

// ==== hdl/ebac_array.sv ====
// Byte storage array held in flip-flops.
// Assumes one write strobe and one registered read port, same clock.
`timescale 1ns/10ps
module ebac_array #(
    parameter int AW = 8
) (
    input  wire logic          mclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    q
);
    localparam int DEPTH = 1 << AW;

    logic [7:0] mem_r [DEPTH];

    // No reset: contents survive controller resets
    always_ff @(posedge mclk) begin
        if (we) begin
            mem_r[addr] <= wdata;
        end
    end

    always_ff @(posedge mclk) begin
        q <= mem_r[addr];
    end
endmodule // ebac_array

// ==== verification/tb_top.sv ====
// Self-checking bench for the byte-wide nonvolatile access controller.
// Assumes ebac_pkg is compiled first; the bench drives the register bus itself.
`timescale 1ns/10ps
module tb_top;
    localparam int WT = 4;
    localparam int TD = 4;
    localparam int RC = 4;
    localparam logic [7:0] LOC = ebac_pkg::LOC_OFS;
    localparam logic [7:0] VAL = ebac_pkg::VAL_OFS;
    localparam logic [7:0] CMD = ebac_pkg::CMD_OFS;
    localparam logic [7:0] SEC = ebac_pkg::CMD_SECTOR;
    logic       mclk;
    logic       nrst;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_sector;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic [7:0] small_rdata;
    logic       done_flag_clr;
    logic       nvm_done_flag;
    logic       nvm_done_pulse;
    logic       nvm_busy;
    logic       rd_taken;
    logic [7:0] rd_q[$];
    logic       pulse_q[$];
    logic [7:0] a;
    logic [7:0] d;
    int         miscompares;
    int         cmp_count;
    int         seed;
    int         cycles;
    int         n;

    ebac_ctrl #(.LOC_BITS(8), .WRITE_TICKS(WT), .READ_CYCLES(RC), .TICK_DIV(TD)) i_dut (
        .mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_sector(sfr_sector),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .done_flag_clr(done_flag_clr), .nvm_done_flag(nvm_done_flag),
        .nvm_done_pulse(nvm_done_pulse), .nvm_busy(nvm_busy));

    // Small variant shares every input; only its read data is watched
    ebac_ctrl #(.LOC_BITS(7), .WRITE_TICKS(WT), .READ_CYCLES(RC), .TICK_DIV(TD)) i_small (
        .mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_sector(sfr_sector),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(small_rdata),
        .done_flag_clr(done_flag_clr), .nvm_done_flag(), .nvm_done_pulse(), .nvm_busy());

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp1(input string what, input logic exp, input logic got);
        cmp8(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Answer lands one edge after the strobe, so compare at the following edge
    always @(posedge mclk) begin
        if (rd_taken) begin
            cmp8("sfr_rdata", rd_q.pop_front(), sfr_rdata);
        end
        if (nvm_done_pulse === 1'b1) begin
            cmp1("pulse_expected", 1'b1, pulse_q.size() > 0);
            if (pulse_q.size() > 0) begin
                void'(pulse_q.pop_front());
            end
            cmp1("done_flag", 1'b1, nvm_done_flag);
        end
        rd_taken <= (sfr_rd === 1'b1) && (nrst === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    // Strobes stay up across back-to-back calls; idle() drops them
    task automatic bus(input logic w, input logic [7:0] sec, input logic [7:0] adr, input logic [7:0] dat);
        sfr_wr     = w;
        sfr_rd     = ~w;
        sfr_sector = sec;
        sfr_addr   = adr;
        sfr_wdata  = dat;
        @(negedge mclk);
    endtask

    task automatic rd(input logic [7:0] sec, input logic [7:0] adr, input logic [7:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, sec, adr, 8'h00);
    endtask

    task automatic idle();
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        @(negedge mclk);
    endtask

    // Caller gives the busy cycles already passed before the first poll
    task automatic wait_idle(input int passed);
        n = passed;
        while (nvm_busy === 1'b1 && n < 40) begin
            n++;
            @(negedge mclk);
        end
    endtask

    task automatic do_write(input logic [7:0] adr, input logic [7:0] dat);
        bus(1'b1, 8'h03, LOC, adr);
        bus(1'b1, 8'h00, VAL, dat);
        bus(1'b1, SEC, CMD, 8'h08);
        bus(1'b1, SEC, CMD, 8'h0c);
        pulse_q.push_back(1'b1);
        rd(SEC, CMD, 8'h0c);
        // Raise fetch permit, then a read start that busy must refuse
        bus(1'b1, SEC, CMD, 8'h0e);
        bus(1'b1, SEC, CMD, 8'h0b);
        rd(SEC, CMD, 8'h0e);
        idle();
        wait_idle(5);
        cmp1("wr_len", 1'b1, n >= (WT - 1) * TD + 1 && n <= WT * TD);
        rd(SEC, CMD, 8'h0a);
        idle();
    endtask

    task automatic do_read(input logic [7:0] adr, input logic [7:0] exp);
        bus(1'b1, 8'h02, VAL, ~exp);
        bus(1'b1, 8'h07, LOC, adr);
        bus(1'b1, SEC, CMD, 8'h02);
        bus(1'b1, SEC, CMD, 8'h03);
        rd(SEC, CMD, 8'h03);
        idle();
        wait_idle(2);
        cmp1("rd_len", 1'b1, n == RC);
        rd(SEC, CMD, 8'h02);
        rd(8'h10, VAL, exp);
        idle();
    endtask

    initial begin
        seed = 32'h93c2;
        nrst = 1'b0;
        done_flag_clr = 1'b0;
        rd_taken = 1'b0;
        cycles = 0;
        miscompares = 0;
        cmp_count = 0;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_sector = 8'h00;
        sfr_wdata = 8'h00;
        repeat (5) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
        rd(SEC, CMD, 8'h00);
        rd(SEC, 8'h55, 8'h00);
        idle();
        cmp1("flag_rst", 1'b0, nvm_done_flag);
        $display("test reset done");
        bus(1'b1, 8'h00, CMD, 8'h0a);
        rd(SEC, CMD, 8'h00);
        bus(1'b1, SEC, CMD, 8'hf2);
        rd(SEC, CMD, 8'h02);
        bus(1'b1, 8'h2c, LOC, 8'hff);
        rd(8'h05, LOC, 8'hff);
        idle();
        cmp8("small_loc", 8'h7f, small_rdata);
        bus(1'b1, SEC, CMD, 8'h00);
        bus(1'b1, SEC, CMD, 8'h01);
        rd(SEC, CMD, 8'h00);
        bus(1'b1, SEC, CMD, 8'h04);
        rd(SEC, CMD, 8'h00);
        bus(1'b1, SEC, CMD, 8'h0a);
        bus(1'b1, SEC, CMD, 8'h0f);
        rd(SEC, CMD, 8'h0a);
        idle();
        cmp1("busy_refused", 1'b0, nvm_busy);
        $display("test decode done");
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            d = 8'($random(seed));
            do_write(a, d);
            bus(1'b1, 8'h00, VAL, ~d);
            bus(1'b1, SEC, CMD, 8'h00);
            bus(1'b1, SEC, CMD, 8'h04);
            idle();
            cmp1("busy_unpermitted", 1'b0, nvm_busy);
            do_read(a, d);
        end
        $display("test write_read done");
        cmp1("flag_sticky", 1'b1, nvm_done_flag);
        done_flag_clr = 1'b1;
        @(negedge mclk);
        done_flag_clr = 1'b0;
        cmp1("flag_clr", 1'b0, nvm_done_flag);
        cmp1("pulses_left", 1'b0, pulse_q.size() > 0);
        $display("test done_flag done");
        stop_test();
    end
endmodule // tb_top
